// file: verification/quad_dsp_module_control_regs_test.sv
`timescale 1ns/1ps
`include "quad_dsp_defs.svh"
module quad_dsp_module_control_regs_test;
  import quad_dsp_pkg::*;
  logic            mclk, nrst, logic_configured, cfg_req, cfg_we, cfg_ack, pci_global_irq;
  logic            mem_space_en, bus_master_en, parity_resp_en, pci_inta, pci_intb;
  logic            led_red_on, led_green_on, tdm_switch_reset_n, tdm_dma_enable;
  logic            tdm_frame, tdm_superframe, p;
  logic            ev_target_abort, ev_master_abort, ev_system_error, ev_parity_error;
  logic [2:0]      slot_id;
  logic [3:0]      cfg_be, evs, core_io_wr, core_io_rd, mem_wr_a22, core_flag_output;
  logic [3:0]      core_external_interrupt, core_reset_n, tdm_rx_en, tdm_tx_en, tdm_buffer_pointer;
  logic [5:0]      tdm_dma_slots;
  logic [31:0]     cfg_addr;
  word_t           cfg_base, cfg_wdata, cfg_rdata, mem_window_base, rd;
  logic [3:0][2:0] core_io_addr;
  logic [3:0][3:0] core_io_wdata, core_io_rdata, dma_err_ev;
  nib_t            n4;
  int              err_total, n_checks;

  assign {ev_parity_error, ev_system_error, ev_master_abort, ev_target_abort} = evs;

  quad_dsp_module_control_regs dut_u (
    .mclk, .nrst, .slot_id, .logic_configured, .cfg_base, .cfg_req, .cfg_we, .cfg_addr,
    .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .ev_target_abort, .ev_master_abort,
    .ev_system_error, .ev_parity_error, .mem_space_en, .bus_master_en, .parity_resp_en,
    .mem_window_base, .pci_inta, .pci_intb, .core_io_wr, .core_io_rd, .core_io_addr,
    .core_io_wdata, .core_io_rdata, .pci_global_irq, .tdm_frame, .tdm_superframe,
    .mem_wr_a22, .dma_err_ev, .core_flag_output, .core_external_interrupt, .core_reset_n,
    .tdm_rx_en, .tdm_tx_en, .tdm_buffer_pointer, .led_red_on, .led_green_on,
    .tdm_switch_reset_n, .tdm_dma_enable, .tdm_dma_slots
  );

  quad_dsp_tdm_model far_u (
    .mclk(mclk), .nrst(nrst), .run(tdm_switch_reset_n),
    .frame(tdm_frame), .superframe(tdm_superframe)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task summarize();
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Single-cycle request; ack is expected one edge later
  task cfg(input logic we, input logic [7:0] ofs, input logic [3:0] be, input word_t wd);
    @(posedge mclk);
    cfg_req <= 1'b1;
    cfg_we <= we;
    cfg_addr <= `SLOT_A_BASE | {24'h0, ofs};
    cfg_be <= be;
    cfg_wdata <= wd;
    @(posedge mclk);
    cfg_req <= 1'b0;
    #1;
    for (int i = 0; i < 4 && cfg_ack !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (cfg_ack !== 1'b1) begin
      err_total++;
      summarize();
    end
    rd = cfg_rdata;
  endtask

  task io(input int n, input logic wr, input logic [2:0] a, input nib_t wd);
    @(posedge mclk);
    core_io_wr[n] <= wr;
    core_io_rd[n] <= !wr;
    core_io_addr[n] <= a;
    core_io_wdata[n] <= wd;
    @(posedge mclk);
    core_io_wr[n] <= 1'b0;
    core_io_rd[n] <= 1'b0;
    #1;
    n4 = core_io_rdata[n];
  endtask

  task pulse(input logic [3:0] e, input logic g, input logic [3:0] m, input nib_t d);
    @(posedge mclk);
    evs <= e;
    pci_global_irq <= g;
    mem_wr_a22 <= m;
    dma_err_ev[0] <= d;
    @(posedge mclk);
    evs <= 4'h0;
    pci_global_irq <= 1'b0;
    mem_wr_a22 <= 4'h0;
    dma_err_ev[0] <= 4'h0;
  endtask

  // Frames run free, so the wait is bounded by about three superframe periods
  task wait_ev(input logic sup);
    for (int i = 0; i < 200 && !(tdm_frame === 1'b1 && tdm_superframe === sup); i++) begin
      @(posedge mclk);
      #1;
    end
    if (tdm_frame !== 1'b1) begin
      err_total++;
      summarize();
    end
    p = tdm_buffer_pointer[0];
    @(posedge mclk);
    #1;
    chk(tdm_buffer_pointer, {4{~p}});
  endtask

  task s_slot();
    // Unused strap codes fall back to the last site
    @(posedge mclk);
    slot_id <= 3'd7;
    repeat (4) @(posedge mclk);
    #1;
    chk(cfg_base, `SLOT_F_BASE);
    for (int i = 5; i >= 0; i--) begin
      @(posedge mclk);
      slot_id <= i[2:0];
      repeat (4) @(posedge mclk);
      #1;
      chk(cfg_base, `SLOT_A_BASE >> i);
    end
  endtask

  task s_cmd_base();
    cfg(1'b1, `CFG_CMD_OFS, 4'hf, 32'hffffffff);
    chk({mem_space_en, bus_master_en, parity_resp_en}, 3'b111);
    pulse(4'hf, 1'b0, 4'h0, 4'h0);
    cfg(1'b0, `CFG_CMD_OFS, 4'hf, 32'h0);
    chk(rd, 32'hf0000046);
    cfg(1'b1, `CFG_CMD_OFS, 4'h8, 32'h10000000);
    cfg(1'b0, `CFG_CMD_OFS, 4'hf, 32'h0);
    chk(rd, 32'he0000046);
    cfg(1'b1, `CFG_BASE_OFS, 4'hf, 32'h12345000);
    chk(mem_window_base, 32'h12345000);
    cfg(1'b0, `CFG_BASE_OFS, 4'hf, 32'h0);
    chk(rd, 32'h0);
    cfg(1'b1, 8'h20, 4'hf, 32'hffffffff);
    cfg(1'b0, 8'h20, 4'hf, 32'h0);
    chk(rd, 32'h0);
  endtask

  task s_ctrl_tdm();
    cfg(1'b1, `CFG_CTRL_OFS, 4'h1, 32'hffffffff);
    cfg(1'b0, `CFG_CTRL_OFS, 4'hf, 32'h0);
    chk(rd, 32'h00000087);
    chk({core_reset_n, tdm_rx_en, tdm_tx_en}, 12'h111);
    cfg(1'b1, `CFG_CTRL_OFS, 4'he, 32'h07070700);
    cfg(1'b0, `CFG_CTRL_OFS, 4'hf, 32'h0);
    chk(rd, 32'h07070787);
    cfg(1'b1, `CFG_TDM_OFS, 4'h8, 32'hbf000000);
    cfg(1'b0, `CFG_TDM_OFS, 4'hf, 32'h0);
    chk(rd, 32'h9f000000);
    chk({tdm_switch_reset_n, tdm_dma_enable, tdm_dma_slots}, {2'b10, 6'd33});
    cfg(1'b1, `CFG_TDM_OFS, 4'h8, 32'hc0000000);
    chk({tdm_dma_enable, tdm_dma_slots}, {1'b1, 6'd2});
    cfg(1'b1, `CFG_TDM_OFS, 4'h8, 32'h80000000);
    chk(tdm_dma_enable, 1'b0);
  endtask

  task s_xirq();
    io(1, 1'b1, IO_REQ, 4'h3);
    chk({pci_intb, pci_inta}, 2'b11);
    cfg(1'b0, `CFG_XIRQ_OFS, 4'h2, 32'h0);
    chk(rd, 32'h00000300);
    chk({pci_intb, pci_inta}, 2'b00);
    cfg(1'b1, `CFG_XIRQ_OFS, 4'h4, 32'h00ff0000);
    io(2, 1'b0, IO_STAT, 4'h0);
    chk(n4 & 4'h2, 4'h2);
    cfg(1'b0, `CFG_XIRQ_OFS, 4'hf, 32'h0);
    cfg(1'b0, `CFG_XIRQ_OFS, 4'hf, 32'h0);
    chk(rd, 32'h00800000);
    io(2, 1'b1, IO_CLR, 4'h2);
    cfg(1'b0, `CFG_XIRQ_OFS, 4'hf, 32'h0);
    chk(rd, 32'h0);
    cfg(1'b1, `CFG_TDM_OFS, 4'h4, 32'h00010000);
    io(0, 1'b1, IO_REQ, 4'h3);
    chk({pci_intb, pci_inta}, 2'b10);
    cfg(1'b1, `CFG_TDM_OFS, 4'h4, 32'h0);
    chk({pci_intb, pci_inta}, 2'b11);
    cfg(1'b0, `CFG_XIRQ_OFS, 4'h1, 32'h0);
    chk(rd, 32'h00000003);
  endtask

  task s_core();
    chk({led_red_on, led_green_on}, 2'b10);
    @(posedge mclk);
    logic_configured <= 1'b1;
    @(posedge mclk);
    #1;
    chk({led_red_on, led_green_on}, 2'b00);
    io(0, 1'b1, IO_CTL, 4'h4);
    io(1, 1'b1, IO_CTL, 4'h0);
    chk({led_red_on, led_green_on}, 2'b01);
    io(0, 1'b1, IO_IE, 4'h4);
    io(0, 1'b0, IO_IE, 4'h0);
    chk(n4, 4'h4);
    wait_ev(1'b0);
    chk(core_external_interrupt, 4'h1);
    io(0, 1'b1, IO_CLR, 4'h4);
    chk(core_external_interrupt, 4'h0);
    io(1, 1'b0, IO_STAT, 4'h0);
    chk(n4, 4'h4);
    io(0, 1'b1, IO_CTL, 4'hc);
    wait_ev(1'b1);
    io(0, 1'b1, IO_CLR, 4'h4);
    wait_ev(1'b0);
    io(0, 1'b0, IO_STAT, 4'h0);
    chk(n4, 4'h0);
    wait_ev(1'b1);
    io(0, 1'b0, IO_STAT, 4'h0);
    chk(n4, 4'h4);
  endtask

  task s_events();
    pulse(4'h0, 1'b1, 4'h8, 4'hb);
    io(3, 1'b0, IO_STAT, 4'h0);
    chk(n4 & 4'hb, 4'h9);
    io(2, 1'b0, IO_STAT, 4'h0);
    chk(n4 & 4'hb, 4'h1);
    io(0, 1'b0, IO_DMA, 4'h0);
    chk(n4, 4'hb);
    @(posedge mclk);
    core_flag_output[0] <= 1'b1;
    repeat (4) @(posedge mclk);
    io(0, 1'b0, IO_DMA, 4'h0);
    chk(n4, 4'h0);
    io(3, 1'b1, IO_CLR, 4'h9);
    io(3, 1'b0, IO_STAT, 4'h0);
    chk(n4 & 4'hb, 4'h0);
    io(3, 1'b0, 3'd5, 4'h0);
    chk(n4, 4'h0);
  endtask

  initial begin
    err_total = 0;
    n_checks = 0;
    nrst = 1'b0;
    slot_id = 3'd0;
    logic_configured = 1'b0;
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 32'h0;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    evs = 4'h0;
    pci_global_irq = 1'b0;
    mem_wr_a22 = 4'h0;
    dma_err_ev = '0;
    core_flag_output = 4'h0;
    core_io_wr = 4'h0;
    core_io_rd = 4'h0;
    core_io_addr = '0;
    core_io_wdata = '0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk({core_reset_n, tdm_switch_reset_n, led_red_on}, 6'h01);
    io(2, 1'b0, IO_CTL, 4'h0);
    chk(n4, `CC_RST_VAL);
    s_slot();
    s_cmd_base();
    s_ctrl_tdm();
    s_xirq();
    s_core();
    s_events();
    summarize();
  end
endmodule

// file: verification/quad_dsp_tdm_model.sv
`timescale 1ns/1ps
module quad_dsp_tdm_model (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Switch released
  input  wire logic run,
  // Frame events
  output      logic frame,
  output      logic superframe
);
  logic [7:0] cnt_q;
  // Frame every 16 cycles, superframe every fourth frame
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
    end else if (run) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // Silent while the switch is held in reset
  assign frame      = run && (cnt_q[3:0] == 4'hf);
  assign superframe = frame && (cnt_q[5:4] == 2'h3);
endmodule

// file: verilog/quad_dsp_defs.svh
`ifndef QUAD_DSP_DEFS_SVH
`define QUAD_DSP_DEFS_SVH
// Configuration-space offsets
`define CFG_CMD_OFS   8'h04
`define CFG_BASE_OFS  8'h10
`define CFG_CTRL_OFS  8'h40
`define CFG_XIRQ_OFS  8'h44
`define CFG_TDM_OFS   8'h48
// Configuration-space slot bases
`define SLOT_A_BASE   32'h01000000
`define SLOT_F_BASE   32'h00080000
// Command/status fields
`define CMD_MEM_BIT   1
`define CMD_MST_BIT   2
`define CMD_PER_BIT   6
`define STS_TABT_BIT  28
`define STS_MABT_BIT  29
`define STS_SERR_BIT  30
`define STS_PERR_BIT  31
// Writable bits of the 32-bit registers
`define CMD_WR_MASK   32'h00000046
`define CTRL_WR_MASK  32'h87878787
`define TDM_WR_MASK   32'hdfff0000
// Fields of the control registers
`define TDM_RST_BIT   31
`define TDM_RUN_BIT   30
`define TDM_CNT_LSB   24
`define TDM_CNT_W     5
`define TDM_CNT_OFS   2
`define MASK_A_LSB    16
`define MASK_B_LSB    20
`define LED_EN_BIT    7
`define RX_EN_BIT     2
`define TX_EN_BIT     1
`define H2C_BIT       7
`define C2P_B_BIT     1
`define C2P_A_BIT     0
// Core-side field positions
`define CC_SEL_BIT    3
`define CC_RED_BIT    2
`define CC_GRN_BIT    1
`define CC_PTR_BIT    0
`define ST_MEM_BIT    3
`define ST_TDM_BIT    2
`define ST_H2C_BIT    1
`define ST_GLB_BIT    0
// Reset values
`define CC_RST_VAL    4'h6
`define CTRL_RST_VAL  32'h00000000
`define TDM_RST_VAL   32'h00000000
`endif

// file: verilog/quad_dsp_module_control_regs.sv
//   Contract
// RULE1: Slot sets config base, halving per slot
// RULE2: Software sets memory, master, parity enables
// RULE3: Error status bits hardware-set, write-one clears
// RULE4: Memory base register defines target window
// RULE5: Control byte n: LED, TDM enables, reset
// RULE6: Interrupt byte n: host-to-core, INTB, INTA
// RULE7: Host-to-core bit set by host, core clears
// RULE8: Core requests clear when host reads them
// RULE9: TDM switch held reset while bit low
// RULE10: Bit 30 runs the TDM DMA controller (code also requires bit 31 high)
// RULE11: DMA count field is slots minus two
// RULE12: Mask bits gate core INTA and INTB
// RULE13: Private 4-bit register set per core
// RULE14: Control bit 3 picks frame or superframe
// RULE15: LED bits low light; red while unconfigured
// RULE16: Buffer pointer toggles only at frame boundary
// RULE17: Write one to clear-register clears condition
// RULE18: Status shows latched conditions, ignoring enables
// RULE19: DMA status clears on flag rising edge
// RULE20: External interrupt from enabled latched conditions
// RULE21: Core request register sets INTA or INTB
// RULE22: Memory write with bit 22 latches condition
// RULE23: Reserved bits read zero, writes ignored
`timescale 1ns/1ps
`include "quad_dsp_defs.svh"
module quad_dsp_module_control_regs #(
  parameter int NCORE = 4
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  // Module site and configuration state
  input  wire logic [2:0]              slot_id,
  input  wire logic                    logic_configured,
  output      quad_dsp_pkg::word_t     cfg_base,
  // Configuration-space access
  input  wire logic                    cfg_req,
  input  wire logic                    cfg_we,
  input  wire logic [31:0]             cfg_addr,
  input  wire logic [3:0]              cfg_be,
  input  wire quad_dsp_pkg::word_t     cfg_wdata,
  output      quad_dsp_pkg::word_t     cfg_rdata,
  output      logic                    cfg_ack,
  // Bus error events
  input  wire logic                    ev_target_abort,
  input  wire logic                    ev_master_abort,
  input  wire logic                    ev_system_error,
  input  wire logic                    ev_parity_error,
  // Bus control outputs
  output      logic                    mem_space_en,
  output      logic                    bus_master_en,
  output      logic                    parity_resp_en,
  output      quad_dsp_pkg::word_t     mem_window_base,
  output      logic                    pci_inta,
  output      logic                    pci_intb,
  // Core-side register ports
  input  wire logic [NCORE-1:0]        core_io_wr,
  input  wire logic [NCORE-1:0]        core_io_rd,
  input  wire logic [NCORE-1:0][2:0]   core_io_addr,
  input  wire logic [NCORE-1:0][3:0]   core_io_wdata,
  output      logic [NCORE-1:0][3:0]   core_io_rdata,
  // Core events and pins
  input  wire logic                    pci_global_irq,
  input  wire logic                    tdm_frame,
  input  wire logic                    tdm_superframe,
  input  wire logic [NCORE-1:0]        mem_wr_a22,
  input  wire logic [NCORE-1:0][3:0]   dma_err_ev,
  input  wire logic [NCORE-1:0]        core_flag_output,
  output      logic [NCORE-1:0]        core_external_interrupt,
  // Core and TDM control outputs
  output      logic [NCORE-1:0]        core_reset_n,
  output      logic [NCORE-1:0]        tdm_rx_en,
  output      logic [NCORE-1:0]        tdm_tx_en,
  output      logic [NCORE-1:0]        tdm_buffer_pointer,
  output      logic                    led_red_on,
  output      logic                    led_green_on,
  output      logic                    tdm_switch_reset_n,
  output      logic                    tdm_dma_enable,
  output      logic [5:0]              tdm_dma_slots
);
  import quad_dsp_pkg::*;

  logic [2:0]             slot_s1_q;
  logic [2:0]             slot_s2_q;
  word_t                  base_q;
  word_t                  cmd_q;
  word_t                  win_q;
  word_t                  ctrl_q;
  word_t                  tdm_q;
  logic [NCORE-1:0]       h2c_q;
  logic [NCORE-1:0]       c2pa_q;
  logic [NCORE-1:0]       c2pb_q;
  logic [NCORE-1:0][3:0]  cc_q;
  logic [NCORE-1:0][2:0]  st_q;
  logic [NCORE-1:0][3:0]  ie_q;
  logic [NCORE-1:0][3:0]  dst_q;
  logic [NCORE-1:0]       flag_s1_q;
  logic [NCORE-1:0]       flag_s2_q;
  logic [NCORE-1:0]       flag_s3_q;
  logic [NCORE-1:0]       flag_rise;
  logic [NCORE-1:0]       tdm_ev;
  logic [NCORE-1:0][3:0]  stat;
  logic [NCORE-1:0]       cw;
  logic [NCORE-1:0]       cr;
  word_t                  wmask;
  word_t                  rd_d;
  logic                   hit;
  logic                   wr;
  logic                   rd;
  logic [7:0]             ofs;

  // Slot strap resynchronised; base follows it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slot_s1_q <= 3'h0;
      slot_s2_q <= 3'h0;
      base_q    <= `SLOT_A_BASE;
    end else begin
      slot_s1_q <= slot_id;
      slot_s2_q <= slot_s1_q;
      if (slot_s2_q <= 3'h5) begin
        base_q <= `SLOT_A_BASE >> slot_s2_q; // RULE1
      end else begin
        base_q <= `SLOT_F_BASE; // RULE1
      end
    end
  end
  assign cfg_base = base_q;

  // Decode within the 256-byte config space
  assign ofs   = cfg_addr[7:0];
  assign hit   = cfg_req && (cfg_addr[31:8] == base_q[31:8]);
  assign wr    = hit && cfg_we;
  assign rd    = hit && !cfg_we;
  assign wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

  // Command bits and write-one-clear status
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= 32'h00000000;
    end else begin
      if (wr && ofs == `CFG_CMD_OFS) begin
        cmd_q <= (cmd_q & ~(`CMD_WR_MASK & wmask)) | (cfg_wdata & `CMD_WR_MASK & wmask); // RULE2 RULE23
        cmd_q[31:28] <= cmd_q[31:28] & ~(cfg_wdata[31:28] & wmask[31:28]); // RULE3
      end
      // Set wins over a simultaneous clear
      if (ev_target_abort) cmd_q[`STS_TABT_BIT] <= 1'b1; // RULE3
      if (ev_master_abort) cmd_q[`STS_MABT_BIT] <= 1'b1; // RULE3
      if (ev_system_error) cmd_q[`STS_SERR_BIT] <= 1'b1; // RULE3
      if (ev_parity_error) cmd_q[`STS_PERR_BIT] <= 1'b1; // RULE3
    end
  end
  assign mem_space_en   = cmd_q[`CMD_MEM_BIT];
  assign bus_master_en  = cmd_q[`CMD_MST_BIT];
  assign parity_resp_en = cmd_q[`CMD_PER_BIT];

  // Window base, core control and TDM control
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      win_q  <= 32'h00000000;
      ctrl_q <= `CTRL_RST_VAL;
      tdm_q  <= `TDM_RST_VAL;
    end else if (wr) begin
      if (ofs == `CFG_BASE_OFS) begin
        win_q <= (win_q & ~wmask) | (cfg_wdata & wmask); // RULE4
      end
      if (ofs == `CFG_CTRL_OFS) begin
        ctrl_q <= (ctrl_q & ~(`CTRL_WR_MASK & wmask)) | (cfg_wdata & `CTRL_WR_MASK & wmask); // RULE5 RULE23
      end
      if (ofs == `CFG_TDM_OFS) begin
        tdm_q <= (tdm_q & ~(`TDM_WR_MASK & wmask)) | (cfg_wdata & `TDM_WR_MASK & wmask); // RULE23
      end
    end
  end
  assign mem_window_base = win_q;
  assign tdm_switch_reset_n = tdm_q[`TDM_RST_BIT]; // RULE9
  assign tdm_dma_enable = tdm_q[`TDM_RUN_BIT] && tdm_q[`TDM_RST_BIT]; // RULE10
  assign tdm_dma_slots = {1'b0, tdm_q[`TDM_CNT_LSB +: `TDM_CNT_W]} + 6'(`TDM_CNT_OFS); // RULE11

  always_comb begin
    for (int n = 0; n < NCORE; n++) begin
      core_reset_n[n] = ctrl_q[8*n]; // RULE5
      tdm_tx_en[n]    = ctrl_q[8*n + `TX_EN_BIT]; // RULE5
      tdm_rx_en[n]    = ctrl_q[8*n + `RX_EN_BIT]; // RULE5
    end
  end

  // Core request decode
  always_comb begin
    for (int n = 0; n < NCORE; n++) begin
      cw[n] = core_io_wr[n];
      cr[n] = core_io_rd[n] && !core_io_wr[n];
    end
  end

  // Cross interrupts between host and cores
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      h2c_q  <= '0;
      c2pa_q <= '0;
      c2pb_q <= '0;
    end else begin
      for (int n = 0; n < NCORE; n++) begin
        if (cw[n] && core_io_addr[n] == IO_CLR && core_io_wdata[n][`ST_H2C_BIT]) begin
          h2c_q[n] <= 1'b0; // RULE7 RULE17
        end
        if (wr && ofs == `CFG_XIRQ_OFS && cfg_be[n] && cfg_wdata[8*n + `H2C_BIT]) begin
          h2c_q[n] <= 1'b1; // RULE6 RULE7
        end
        if (rd && ofs == `CFG_XIRQ_OFS && cfg_be[n]) begin
          c2pa_q[n] <= 1'b0; // RULE8
          c2pb_q[n] <= 1'b0; // RULE8
        end
        // A request landing on the clearing read survives
        if (cw[n] && core_io_addr[n] == IO_REQ) begin
          if (core_io_wdata[n][`C2P_A_BIT]) c2pa_q[n] <= 1'b1; // RULE21
          if (core_io_wdata[n][`C2P_B_BIT]) c2pb_q[n] <= 1'b1; // RULE21
        end
      end
    end
  end
  assign pci_inta = |(c2pa_q & ~tdm_q[`MASK_A_LSB +: NCORE]); // RULE12
  assign pci_intb = |(c2pb_q & ~tdm_q[`MASK_B_LSB +: NCORE]); // RULE12

  // Configuration read data and acknowledge
  always_comb begin
    rd_d = 32'h00000000;
    unique case (ofs)
      `CFG_CMD_OFS:  rd_d = cmd_q;
      `CFG_CTRL_OFS: rd_d = ctrl_q;
      `CFG_TDM_OFS:  rd_d = tdm_q;
      `CFG_XIRQ_OFS: begin
        for (int n = 0; n < NCORE; n++) begin
          rd_d[8*n + `H2C_BIT]   = h2c_q[n]; // RULE7
          rd_d[8*n + `C2P_B_BIT] = c2pb_q[n]; // RULE6
          rd_d[8*n + `C2P_A_BIT] = c2pa_q[n]; // RULE6
        end
      end
      default: rd_d = 32'h00000000; // RULE23
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata <= 32'h00000000;
      cfg_ack   <= 1'b0;
    end else begin
      cfg_ack <= hit;
      if (rd) begin
        cfg_rdata <= rd_d & wmask;
      end
    end
  end

  // Flag pin synchroniser and rise detect
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flag_s1_q <= '0;
      flag_s2_q <= '0;
      flag_s3_q <= '0;
    end else begin
      flag_s1_q <= core_flag_output;
      flag_s2_q <= flag_s1_q;
      flag_s3_q <= flag_s2_q;
    end
  end
  assign flag_rise = flag_s2_q & ~flag_s3_q;

  // Core control: event select, LEDs, buffer pointer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cc_q <= {NCORE{`CC_RST_VAL}};
    end else begin
      for (int n = 0; n < NCORE; n++) begin
        if (cw[n] && core_io_addr[n] == IO_CTL) begin
          cc_q[n][3:1] <= core_io_wdata[n][3:1]; // RULE13 RULE14 RULE15
        end
        if (tdm_frame) begin
          cc_q[n][`CC_PTR_BIT] <= ~cc_q[n][`CC_PTR_BIT]; // RULE16
        end
      end
    end
  end

  always_comb begin
    led_red_on   = !logic_configured; // RULE15
    led_green_on = 1'b0;
    for (int n = 0; n < NCORE; n++) begin
      tdm_buffer_pointer[n] = cc_q[n][`CC_PTR_BIT];
      tdm_ev[n] = cc_q[n][`CC_SEL_BIT] ? tdm_superframe : tdm_frame; // RULE14
      // Several enabled cores share the LED wire-or style
      if (logic_configured && ctrl_q[8*n + `LED_EN_BIT]) begin
        led_red_on   = led_red_on | !cc_q[n][`CC_RED_BIT]; // RULE15
        led_green_on = led_green_on | !cc_q[n][`CC_GRN_BIT]; // RULE15
      end
    end
  end

  // Latched conditions; host-to-core bit lives in the shared register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      for (int n = 0; n < NCORE; n++) begin
        if (cw[n] && core_io_addr[n] == IO_CLR) begin
          if (core_io_wdata[n][`ST_MEM_BIT]) st_q[n][2] <= 1'b0; // RULE17
          if (core_io_wdata[n][`ST_TDM_BIT]) st_q[n][1] <= 1'b0; // RULE17
          if (core_io_wdata[n][`ST_GLB_BIT]) st_q[n][0] <= 1'b0; // RULE17
        end
        if (mem_wr_a22[n]) st_q[n][2] <= 1'b1; // RULE22
        if (tdm_ev[n]) st_q[n][1] <= 1'b1; // RULE14
        if (pci_global_irq) st_q[n][0] <= 1'b1;
      end
    end
  end

  always_comb begin
    for (int n = 0; n < NCORE; n++) begin
      stat[n] = {st_q[n][2], st_q[n][1], h2c_q[n], st_q[n][0]}; // RULE18
      core_external_interrupt[n] = |(stat[n] & ie_q[n]); // RULE20
    end
  end

  // Enables and global DMA status
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ie_q  <= '0;
      dst_q <= '0;
    end else begin
      for (int n = 0; n < NCORE; n++) begin
        if (cw[n] && core_io_addr[n] == IO_IE) begin
          ie_q[n] <= core_io_wdata[n]; // RULE13
        end
        if (flag_rise[n]) begin
          dst_q[n] <= dma_err_ev[n]; // RULE19
        end else begin
          dst_q[n] <= dst_q[n] | dma_err_ev[n]; // RULE19
        end
      end
    end
  end

  // Core read data, one cycle after the strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      core_io_rdata <= '0;
    end else begin
      for (int n = 0; n < NCORE; n++) begin
        if (cr[n]) begin
          unique case (core_io_addr[n])
            IO_CTL:  core_io_rdata[n] <= cc_q[n]; // RULE13
            IO_STAT: core_io_rdata[n] <= stat[n]; // RULE18
            IO_DMA:  core_io_rdata[n] <= dst_q[n]; // RULE19
            IO_IE:   core_io_rdata[n] <= ie_q[n];
            default: core_io_rdata[n] <= 4'h0; // RULE23
          endcase
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_xirq_read0;
    rd && ofs == `CFG_XIRQ_OFS && cfg_be[0];
  endsequence
  sequence s_no_req0;
    !(cw[0] && core_io_addr[0] == IO_REQ);
  endsequence

  a_slot_base: assert property ((slot_s2_q == 3'h2) [*2] |-> cfg_base == 32'h00400000) // RULE1
    else $error("slot base wrong");
  a_sts_w1c: assert property (wr && ofs == `CFG_CMD_OFS && cfg_be[3] && cfg_wdata[28] && !ev_target_abort
    |=> !cmd_q[28]) // RULE3
    else $error("status bit not cleared");
  a_sts_set: assert property (ev_parity_error |=> cmd_q[31] ##1 (cmd_q[31] || $past(wr))) // RULE3
    else $error("status bit not set");
  a_h2c_set: assert property (wr && ofs == `CFG_XIRQ_OFS && cfg_be[2] && cfg_wdata[23] |=> h2c_q[2]) // RULE7
    else $error("host to core not set");
  a_c2p_clear: assert property (s_xirq_read0 and s_no_req0 |=> !c2pa_q[0] && !c2pb_q[0]) // RULE8
    else $error("core request not cleared");
  a_mask_gate: assert property (tdm_q[`MASK_A_LSB] && c2pa_q[NCORE-1:1] == '0 |-> !pci_inta) // RULE12
    else $error("masked inta active");
  a_tdm_count: assert property (tdm_q[28:24] == 5'h1f |-> tdm_dma_slots == 6'd33) // RULE11
    else $error("slot count wrong");
  a_dma_clear: assert property (flag_rise[0] && dma_err_ev[0] == 4'h0 |=> dst_q[0] == 4'h0) // RULE19
    else $error("dma status not cleared");
  a_mem_latch: assert property (mem_wr_a22[3] |=> stat[3][3] ##1 (stat[3][3] || $past(cw[3]))) // RULE22
    else $error("memory write not latched");
  a_buf_toggle: assert property (tdm_frame |=> tdm_buffer_pointer[0] != $past(tdm_buffer_pointer[0])) // RULE16
    else $error("buffer pointer not toggled");
  a_ext_irq: assert property (ie_q[3] == 4'h0 |-> !core_external_interrupt[3]) // RULE20
    else $error("disabled interrupt active");
  a_tdm_reset: assert property (!tdm_q[31] |-> !tdm_switch_reset_n && !tdm_dma_enable) // RULE9
    else $error("tdm reset released");
endmodule

// file: verilog/quad_dsp_pkg.sv
package quad_dsp_pkg;
  typedef logic [3:0] nib_t;
  typedef logic [31:0] word_t;
  typedef enum logic [2:0] {
    IO_CTL  = 3'b000,
    IO_CLR  = 3'b001,
    IO_STAT = 3'b010,
    IO_DMA  = 3'b011,
    IO_IE   = 3'b100,
    IO_REQ  = 3'b111
  } io_reg_e;
endpackage
